// ===== dv/rbw_reset_unit_test.sv
// Self-checking testbench for the reset generation unit
`timescale 1ns/100ps
module rbw_reset_unit_test;
  import rbw_pkg::*;
  localparam int unsigned DIV = 4;
  localparam int unsigned WDT = 64;
  logic         i_clk_sys     = 1'b0;
  logic         i_rst         = 1'b1;
  rbw_sfr_req_s i_sfr         = '0;
  rbw_mode_e    i_mode        = RBW_MODE_FAST;
  logic         i_ext_rst_n   = 1'b1;
  logic         i_below_level = 1'b0;
  logic         i_below_por   = 1'b0;
  logic [7:0]   o_sfr_rdata;
  logic         o_cfg_rd;
  logic [15:0]  o_cfg_addr;
  logic [7:0]   i_cfg_data;
  logic [47:0]  o_cfg_word;
  rbw_bor_ctl_s o_bor_ctl;
  rbw_rst_src_s o_rst_cause;
  logic         o_sys_rst;
  logic [7:0]   nv_mem [6]    = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h68};
  rbw_mode_e    modes [5]     = '{RBW_MODE_FAST, RBW_MODE_SLOW, RBW_MODE_IDLE,
                                  RBW_MODE_STOP, RBW_MODE_HALT};
  int           errors        = 0;
  int           cmp_count     = 0;

  // Program memory tail answers in the same cycle
  assign i_cfg_data = (o_cfg_rd && o_cfg_addr >= 16'h3FFA) ?
                      nv_mem[o_cfg_addr[2:0] - 3'h2] : 8'h00;

  always #12.5 i_clk_sys = ~i_clk_sys;

  rbw_reset_unit #(.WARMUP_CYC(4), .WDT_CYC(WDT), .DIV_CYC(DIV)) dut (
    .i_clk_sys     (i_clk_sys),
    .i_rst         (i_rst),
    .i_sfr         (i_sfr),
    .o_sfr_rdata   (o_sfr_rdata),
    .i_mode        (i_mode),
    .i_ext_rst_n   (i_ext_rst_n),
    .i_below_level (i_below_level),
    .i_below_por   (i_below_por),
    .o_cfg_rd      (o_cfg_rd),
    .o_cfg_addr    (o_cfg_addr),
    .i_cfg_data    (i_cfg_data),
    .o_cfg_word    (o_cfg_word),
    .o_bor_ctl     (o_bor_ctl),
    .o_rst_cause   (o_rst_cause),
    .o_sys_rst     (o_sys_rst)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // Address is held with rd after the write so the F8h pulse can be seen
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    i_sfr <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge i_clk_sys);
    i_sfr <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_sfr <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    #1;
    chk("sfr_rdata", {40'h0, exp}, {40'h0, o_sfr_rdata});
  endtask : rd

  // Bounded wait for the internal reset to reach a level
  task automatic wait_rst(input logic val, input int bound, output int n);
    n = 0;
    #1;
    while (o_sys_rst !== val) begin
      if (n >= bound) begin
        errors++;
        $display("Error o_sys_rst expected %0b seen %0b", val, o_sys_rst);
        give_verdict();
      end
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask : wait_rst

  task automatic quiet(input int cyc, output bit hit);
    // Settle first so a pulse launched at the caller's edge is not missed
    #1;
    hit = (o_sys_rst !== 1'b0);
    repeat (cyc) begin
      @(posedge i_clk_sys);
      #1;
      if (o_sys_rst !== 1'b0) hit = 1'b1;
    end
  endtask : quiet

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic power_up();
    int n;
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    wait_rst(1'b0, 400, n);
    chk("warmup", 1, n >= 4 * DIV + 6);
    chk("cfg_word", {nv_mem[5], nv_mem[4], nv_mem[3], nv_mem[2], nv_mem[1], nv_mem[0]},
        o_cfg_word);
    rd(OFS_WDT_RATE, RST_WDT_RATE);
    rd(OFS_WDT_PWR_CTRL, RST_WDT_PWR_CTRL);
    rd(OFS_CLEAR_SELECT, RST_CLEAR_SELECT);
    rd(OFS_SW_COMMAND, 8'h00);
    rd(8'h80, 8'h00);
  endtask : power_up

  task automatic bor_table();
    bit en;
    bit por;
    bit hit;
    int n;
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge i_clk_sys);
        i_mode <= modes[m];
        wr(OFS_WDT_PWR_CTRL, {2'b00, k[1], 2'b00, 2'b11, k[0]});
        #1;
        en  = !k[0] && (m < 2 || !k[1]);
        por = !en && (m < 3);
        chk("bor_ctl", {en, 3'b101, por, en | por}, o_bor_ctl);
      end
    end
    @(posedge i_clk_sys);
    i_mode        <= RBW_MODE_FAST;
    i_below_level <= 1'b1;
    quiet(20, hit);
    chk("bor_off", 0, hit);
    wr(OFS_WDT_PWR_CTRL, 8'h06);
    wait_rst(1'b1, 4, n);
    chk("cause_bor", 1, o_rst_cause.brownout);
    @(posedge i_clk_sys);
    i_below_level <= 1'b0;
    wait_rst(1'b0, 400, n);
    // Powered-down brown-out leaves only the power-up detector while running
    wr(OFS_WDT_PWR_CTRL, 8'h07);
    @(posedge i_clk_sys);
    i_below_por <= 1'b1;
    wait_rst(1'b1, 4, n);
    chk("cause_por", 4'h0, o_rst_cause);
    @(posedge i_clk_sys);
    i_below_por <= 1'b0;
    wait_rst(1'b0, 400, n);
  endtask : bor_table

  task automatic sw_reset();
    bit hit;
    int n;
    wr(OFS_WDT_RATE, 8'hFF);
    #1;
    chk("rate_mask", MASK_WDT_RATE, o_sfr_rdata);
    wr(OFS_SW_COMMAND, 8'h55);
    quiet(10, hit);
    chk("wrong_key", 0, hit);
    wr(OFS_SW_COMMAND, SW_RESET_KEY);
    wait_rst(1'b1, 4, n);
    chk("cause_sw", 1, o_rst_cause.software);
    wait_rst(1'b0, 400, n);
    rd(OFS_WDT_RATE, RST_WDT_RATE);
  endtask : sw_reset

  task automatic pin_reset(input logic [7:0] cfg);
    bit hit;
    int n;
    nv_mem[5] = cfg;
    power_up();
    @(posedge i_clk_sys);
    i_ext_rst_n <= 1'b0;
    if (cfg[6]) begin
      wait_rst(1'b1, 3 * DIV + 12, n);
      chk("cause_pin", 1, o_rst_cause.pin);
    end else begin
      quiet(40, hit);
      chk("pin_ignored", 0, hit);
    end
    @(posedge i_clk_sys);
    i_ext_rst_n <= 1'b1;
    wait_rst(1'b0, 400, n);
  endtask : pin_reset

  // Overflow time per prescale code, alternating fast and slow modes
  task automatic wdt_period();
    int n;
    int t;
    for (int p = 0; p < 4; p++) begin
      t = (WDT >> p) * DIV;
      @(posedge i_clk_sys);
      i_mode <= p[0] ? RBW_MODE_SLOW : RBW_MODE_FAST;
      wr(OFS_WDT_RATE, 8'(p << POS_PRESCALE));
      wr(OFS_WDT_PWR_CTRL, 8'h86);
      wr(OFS_CLEAR_SELECT, 8'h80);
      wait_rst(1'b1, t + 2 * DIV + 6, n);
      chk("wdt_early", 1, n + DIV + 4 >= t);
      chk("cause_wdt", 1, o_rst_cause.watchdog);
      wait_rst(1'b0, 400, n);
    end
  endtask : wdt_period

  task automatic wdt_control();
    bit hit;
    bit any;
    int n;
    any = 1'b0;
    wr(OFS_WDT_RATE, 8'h30);
    wr(OFS_WDT_PWR_CTRL, 8'h86);
    wr(OFS_CLEAR_SELECT, 8'h80);
    #1;
    chk("clr_set", 8'h80, o_sfr_rdata);
    rd(OFS_CLEAR_SELECT, 8'h00);
    // Clearing well inside the 32-cycle period keeps the counter from overflowing
    repeat (8) begin
      quiet(14, hit);
      any |= hit;
      wr(OFS_CLEAR_SELECT, 8'h80);
    end
    chk("wdt_cleared", 0, any);
    @(posedge i_clk_sys);
    i_mode <= RBW_MODE_IDLE;
    quiet(100, hit);
    chk("wdt_run_only", 0, hit);
    wr(OFS_WDT_PWR_CTRL, 8'hC6);
    wait_rst(1'b1, 60, n);
    chk("wdt_always", 1, o_rst_cause.watchdog);
    wait_rst(1'b0, 400, n);
    @(posedge i_clk_sys);
    i_mode <= RBW_MODE_FAST;
    wr(OFS_WDT_RATE, 8'h30);
    wr(OFS_WDT_PWR_CTRL, 8'h46);
    wr(OFS_CLEAR_SELECT, 8'h80);
    quiet(100, hit);
    chk("wdt_off", 0, hit);
  endtask : wdt_control

  initial begin
    power_up();
    bor_table();
    sw_reset();
    pin_reset(8'h68);
    pin_reset(8'h28);
    pin_reset(8'h68);
    wdt_period();
    wdt_control();
    give_verdict();
  end
endmodule : rbw_reset_unit_test

// ===== hw/rbw_reset_unit.sv
// Reset generation unit: five sources, watchdog, brown-out power control
//
// How it works
// - three config bits pick eight brown-out levels
// - detector resets in run; sleep only without power-save
// - power-save disables brown-out reset in sleep modes
// - disabled: POR-only when running/idle, off in stop/halt
// - power-down bit disables brown-out in every mode
// - every reset restores register defaults
// - power-up waits 40 ms, loads config, releases
// - pin low two slow cycles resets device
// - pin honoured only when config enable bit set
// - writing 56h to command register resets
// - watchdog counts slow oscillator in fast/slow
// - prescale picks 400/200/100/50 ms overflow
// - control field: off, run-only, or always
// - watchdog cleared by reset or clear bit
// - clear bit self-clears next cycle
// - slow time base is nominal 80 kHz
`timescale 1ns/100ps
module rbw_reset_unit #(
  parameter int unsigned WARMUP_CYC = rbw_pkg::WARMUP_TICKS,
  parameter int unsigned WDT_CYC    = rbw_pkg::WDT_BASE_TICKS,
  parameter int unsigned DIV_CYC    = rbw_pkg::SLOW_DIV
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire rbw_pkg::rbw_sfr_req_s i_sfr,
  output logic [7:0]                 o_sfr_rdata,
  input  wire rbw_pkg::rbw_mode_e    i_mode,
  input  wire logic                  i_ext_rst_n,
  input  wire logic                  i_below_level,
  input  wire logic                  i_below_por,
  output logic                       o_cfg_rd,
  output logic [15:0]                o_cfg_addr,
  input  wire logic [7:0]            i_cfg_data,
  output logic [47:0]                o_cfg_word,
  output rbw_pkg::rbw_bor_ctl_s      o_bor_ctl,
  output rbw_pkg::rbw_rst_src_s      o_rst_cause,
  output logic                       o_sys_rst
);
  import rbw_pkg::*;

  // Counters are 24 and 16 bits wide; the shortest prescale period needs WDT_CYC of 8
  if (WARMUP_CYC < 1 || WARMUP_CYC > 24'hFFFFFF || WDT_CYC < 8 || WDT_CYC > 16'hFFFF ||
      DIV_CYC < 2 || DIV_CYC > 16'hFFFF) begin : g_bad_timing
    $error("rbw_reset_unit: timing parameters out of range");
  end

  function automatic logic is_sleep(input rbw_mode_e m);
    is_sleep = (m == RBW_MODE_IDLE) || (m == RBW_MODE_STOP) || (m == RBW_MODE_HALT);
  endfunction : is_sleep

  function automatic logic is_deep(input rbw_mode_e m);
    is_deep = (m == RBW_MODE_STOP) || (m == RBW_MODE_HALT);
  endfunction : is_deep

  // ---------------------------------------------------------------
  // Slow time base and pin synchroniser
  // ---------------------------------------------------------------
  logic [15:0] div_cnt, next_div_cnt;
  logic        slow_tick;
  logic [2:0]  pin_sync;
  logic        pin_low, next_pin_low;
  logic [1:0]  pin_cnt, next_pin_cnt;

  always_comb begin
    slow_tick    = (div_cnt == 16'(DIV_CYC - 1));
    next_div_cnt = slow_tick ? 16'h0000 : div_cnt + 16'h0001;
    next_pin_low = pin_low;
    next_pin_cnt = pin_cnt;
    // Glitches shorter than two slow ticks never reach the reset tree
    if (pin_sync[2] != pin_sync[1]) begin
      next_pin_cnt = 2'h0;
    end else if (pin_sync[2] == pin_low) begin
      next_pin_cnt = 2'h0;
    end else if (slow_tick) begin
      next_pin_cnt = pin_cnt + 2'h1;
      if (pin_cnt == 2'(PIN_MIN_SLOW_CYC - 1)) begin
        next_pin_low = ~pin_low;
        next_pin_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    pin_sync <= {pin_sync[1:0], ~i_ext_rst_n};
    if (i_rst) begin
      div_cnt <= 16'h0000;
      pin_low <= 1'b0;
      pin_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
      pin_low <= next_pin_low;
      pin_cnt <= next_pin_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Power-up sequence and configuration load
  // ---------------------------------------------------------------
  rbw_state_e  state, next_state;
  logic [23:0] warm_cnt, next_warm_cnt;
  logic [2:0]  load_idx, next_load_idx;
  logic [47:0] cfg_word, next_cfg_word;
  logic [7:0]  cfg_high;

  always_comb begin
    next_state    = state;
    next_warm_cnt = warm_cnt;
    next_load_idx = load_idx;
    next_cfg_word = cfg_word;
    case (state)
      RBW_ST_WARMUP: begin
        if (slow_tick) begin
          next_warm_cnt = warm_cnt + 24'h000001;
          if (warm_cnt == 24'(WARMUP_CYC - 1)) begin
            next_state = RBW_ST_LOAD;
          end
        end
      end
      RBW_ST_LOAD: begin
        // Byte k of the word comes from the k-th address above the lowest one (3FFAh + k)
        next_cfg_word = {i_cfg_data, cfg_word[47:8]};
        next_load_idx = load_idx + 3'h1;
        if (load_idx == 3'(NV_CFG_BYTES - 1)) begin
          next_state = RBW_ST_RUN;
        end
      end
      RBW_ST_RUN:    next_state = RBW_ST_RUN;
      default:       next_state = RBW_ST_WARMUP;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state    <= RBW_ST_WARMUP;
      warm_cnt <= 24'h000000;
      load_idx <= 3'h0;
      cfg_word <= 48'h000000000000;
    end else begin
      state    <= next_state;
      warm_cnt <= next_warm_cnt;
      load_idx <= next_load_idx;
      cfg_word <= next_cfg_word;
    end
  end

  assign o_cfg_rd   = (state == RBW_ST_LOAD);
  assign o_cfg_addr = OFS_NV_CFG_HIGH - 16'(NV_CFG_BYTES - 1) + {13'h0000, load_idx};
  assign o_cfg_word = cfg_word;
  assign cfg_high   = cfg_word[47:40];

  // ---------------------------------------------------------------
  // Reset sources and combined reset
  // ---------------------------------------------------------------
  rbw_bor_ctl_s bor;
  rbw_rst_src_s src;
  logic [7:0]   wdt_rate, next_wdt_rate;
  logic [7:0]   wdt_pwr, next_wdt_pwr;
  logic [7:0]   clr_sel, next_clr_sel;
  logic         sw_hit, wdt_ovf, pwr_up, run_rst, sys_rst;

  always_comb begin
    bor.bor_level   = cfg_high[POS_BOR_LEVEL +: 3];
    bor.bor_enable  = ~wdt_pwr[POS_BOR_PDOWN]
                      & ~(wdt_pwr[POS_POWER_SAVE] & is_sleep(i_mode));
    bor.detector_on = bor.bor_enable | ~is_deep(i_mode);
    bor.por_only    = ~bor.bor_enable & ~is_deep(i_mode);
  end
  assign o_bor_ctl = bor;

  assign pwr_up  = (state != RBW_ST_RUN);
  assign sw_hit  = i_sfr.wr && i_sfr.addr == OFS_SW_COMMAND && i_sfr.wdata == SW_RESET_KEY;
  always_comb begin
    src.pin      = pin_low & cfg_high[POS_PIN_RST_EN] & ~pwr_up;
    src.software = sw_hit;
    src.watchdog = wdt_ovf;
    src.brownout = bor.bor_enable & i_below_level & ~pwr_up;
  end
  assign run_rst = |src | (bor.por_only & i_below_por);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sys_rst     <= 1'b1;
      o_rst_cause <= '0;
    end else begin
      sys_rst <= pwr_up | run_rst;
      if (run_rst) begin
        o_rst_cause <= src;
      end
    end
  end
  assign o_sys_rst = sys_rst;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_comb begin
    next_wdt_rate = wdt_rate;
    next_wdt_pwr  = wdt_pwr;
    next_clr_sel  = clr_sel;
    next_clr_sel[POS_WDT_CLEAR] = 1'b0;
    if (i_sfr.wr) begin
      case (i_sfr.addr)
        OFS_WDT_RATE:     next_wdt_rate = i_sfr.wdata & MASK_WDT_RATE;
        OFS_WDT_PWR_CTRL: next_wdt_pwr  = i_sfr.wdata & MASK_WDT_PWR_CTRL;
        OFS_CLEAR_SELECT: next_clr_sel  = i_sfr.wdata;
        default:          next_clr_sel  = next_clr_sel;
      endcase
    end
    if (sys_rst) begin
      next_wdt_rate = RST_WDT_RATE;
      next_wdt_pwr  = RST_WDT_PWR_CTRL;
      next_clr_sel  = RST_CLEAR_SELECT;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wdt_rate <= RST_WDT_RATE;
      wdt_pwr  <= RST_WDT_PWR_CTRL;
      clr_sel  <= RST_CLEAR_SELECT;
    end else begin
      wdt_rate <= next_wdt_rate;
      wdt_pwr  <= next_wdt_pwr;
      clr_sel  <= next_clr_sel;
    end
  end

  always_comb begin
    case (i_sfr.addr)
      OFS_WDT_RATE:     o_sfr_rdata = wdt_rate;
      OFS_SW_COMMAND:   o_sfr_rdata = 8'h00;
      OFS_WDT_PWR_CTRL: o_sfr_rdata = wdt_pwr;
      OFS_CLEAR_SELECT: o_sfr_rdata = clr_sel;
      default:          o_sfr_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  logic [15:0] wdt_cnt, next_wdt_cnt;
  logic [15:0] wdt_limit;
  logic        wdt_count_en, wdt_rst_en, wdt_wrap;

  always_comb begin
    wdt_limit    = 16'(WDT_CYC) >> wdt_rate[POS_PRESCALE +: 2];
    wdt_count_en = ~is_sleep(i_mode) | (wdt_pwr[POS_WDT_CTRL +: 2] == 2'b11);
    wdt_rst_en   = wdt_pwr[POS_WDT_CTRL + 1] & wdt_count_en;
    // Wrap at the period even while the reset is off, so enabling it later
    // or shortening the period never waits for a full 16-bit roll-over
    wdt_wrap     = wdt_count_en & slow_tick & (wdt_cnt >= wdt_limit - 16'h0001);
    wdt_ovf      = wdt_rst_en & wdt_wrap;
    next_wdt_cnt = wdt_cnt;
    if (sys_rst || clr_sel[POS_WDT_CLEAR] || wdt_wrap) begin
      next_wdt_cnt = 16'h0000;
    end else if (wdt_count_en && slow_tick) begin
      next_wdt_cnt = wdt_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wdt_cnt <= 16'h0000;
    end else begin
      wdt_cnt <= next_wdt_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_clear_self;
    @(posedge i_clk_sys) disable iff (i_rst)
      clr_sel[POS_WDT_CLEAR] && !(i_sfr.wr && i_sfr.addr == OFS_CLEAR_SELECT)
      |=> !clr_sel[POS_WDT_CLEAR];
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear bit stuck");

  property p_sw_reset;
    @(posedge i_clk_sys) disable iff (i_rst) sw_hit |=> o_sys_rst;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missed");

  property p_defaults;
    @(posedge i_clk_sys) disable iff (i_rst)
      o_sys_rst |=> wdt_pwr == RST_WDT_PWR_CTRL && wdt_rate == RST_WDT_RATE;
  endproperty
  a_defaults: assert property (p_defaults) else $error("register default lost");

  property p_pdown;
    @(posedge i_clk_sys) disable iff (i_rst) wdt_pwr[POS_BOR_PDOWN] |-> !o_bor_ctl.bor_enable;
  endproperty
  a_pdown: assert property (p_pdown) else $error("brown-out enabled in power down");

  property p_save;
    @(posedge i_clk_sys) disable iff (i_rst)
      wdt_pwr[POS_POWER_SAVE] && is_deep(i_mode) |-> !o_bor_ctl.detector_on;
  endproperty
  a_save: assert property (p_save) else $error("detector on in deep sleep");

  property p_run_bor;
    @(posedge i_clk_sys) disable iff (i_rst)
      !wdt_pwr[POS_BOR_PDOWN] && !is_sleep(i_mode) |-> o_bor_ctl.bor_enable;
  endproperty
  a_run_bor: assert property (p_run_bor) else $error("brown-out off while running");

  property p_pin_ignored;
    @(posedge i_clk_sys) disable iff (i_rst) !cfg_high[POS_PIN_RST_EN] |-> !o_rst_cause.pin;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin reset while disabled");

  property p_wdt_clear;
    @(posedge i_clk_sys) disable iff (i_rst) clr_sel[POS_WDT_CLEAR] |=> wdt_cnt == 16'h0000;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

  property p_wdt_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      !wdt_count_en && !o_sys_rst && !clr_sel[POS_WDT_CLEAR] |=> $stable(wdt_cnt);
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog counted in sleep");

  property p_load;
    @(posedge i_clk_sys) disable iff (i_rst)
      state == RBW_ST_LOAD && load_idx == 3'h0 |-> o_sys_rst ##6 state == RBW_ST_RUN;
  endproperty
  a_load: assert property (p_load) else $error("config load length wrong");
endmodule : rbw_reset_unit

// ===== include/rbw_pkg.sv
// Package: register map, field layout, reset values and timing for the reset unit
package rbw_pkg;
  localparam logic [7:0]  OFS_WDT_RATE      = 8'h94;
  localparam logic [7:0]  OFS_SW_COMMAND    = 8'h97;
  localparam logic [7:0]  OFS_WDT_PWR_CTRL  = 8'hF7;
  localparam logic [7:0]  OFS_CLEAR_SELECT  = 8'hF8;
  localparam logic [15:0] OFS_NV_CFG_HIGH   = 16'h3FFF;
  localparam int unsigned NV_CFG_BYTES      = 6;

  localparam logic [7:0]  RST_WDT_RATE      = 8'h00;
  localparam logic [7:0]  RST_WDT_PWR_CTRL  = 8'h06;
  localparam logic [7:0]  RST_CLEAR_SELECT  = 8'h00;
  localparam logic [7:0]  SW_RESET_KEY      = 8'h56;

  localparam int unsigned POS_PRESCALE      = 4;
  localparam int unsigned POS_WDT_CTRL      = 6;
  localparam int unsigned POS_POWER_SAVE    = 5;
  localparam int unsigned POS_BOR_PDOWN     = 0;
  localparam int unsigned POS_WDT_CLEAR     = 7;
  localparam int unsigned POS_PIN_RST_EN    = 6;
  localparam int unsigned POS_BOR_LEVEL     = 3;

  localparam logic [7:0]  MASK_WDT_RATE     = 8'hBC;
  localparam logic [7:0]  MASK_WDT_PWR_CTRL = 8'hF7;

  // Timing figures and derived cycle counts
  localparam int unsigned SYS_CLK_HZ        = 40_000_000;
  localparam int unsigned SLOW_OSC_HZ       = 80_000;
  localparam int unsigned WARMUP_MS         = 40;
  localparam int unsigned WDT_BASE_MS       = 400;
  localparam int unsigned PIN_MIN_SLOW_CYC  = 2;
  localparam int unsigned SLOW_DIV          = SYS_CLK_HZ / SLOW_OSC_HZ;
  localparam int unsigned WARMUP_TICKS      = WARMUP_MS * SLOW_OSC_HZ / 1000;
  localparam int unsigned WDT_BASE_TICKS    = WDT_BASE_MS * SLOW_OSC_HZ / 1000;

  typedef enum logic [4:0] {
    RBW_MODE_FAST = 5'b00001,
    RBW_MODE_SLOW = 5'b00010,
    RBW_MODE_IDLE = 5'b00100,
    RBW_MODE_STOP = 5'b01000,
    RBW_MODE_HALT = 5'b10000
  } rbw_mode_e;

  typedef enum logic [2:0] {
    RBW_ST_WARMUP = 3'b001,
    RBW_ST_LOAD   = 3'b010,
    RBW_ST_RUN    = 3'b100
  } rbw_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rbw_sfr_req_s;

  typedef struct packed {
    logic       bor_enable;
    logic [2:0] bor_level;
    logic       por_only;
    logic       detector_on;
  } rbw_bor_ctl_s;

  typedef struct packed {
    logic pin;
    logic software;
    logic watchdog;
    logic brownout;
  } rbw_rst_src_s;
endpackage : rbw_pkg
